/* dv/flash_array_model.sv */
`default_nettype none
module flash_array_model
  import flash_seq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // two pages only, upper address bits ignored
  logic [7:0] mem [256];
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
  end
  // stores raw data so a missing 1 to 0 mask shows up
  always @(posedge clk)
  begin
    if (we) mem[addr[7:0]] <= wdata;
  end
  assign rdata = mem[addr[7:0]];
endmodule : flash_array_model
`default_nettype wire

/* dv/flash_program_write_control_assertions.sv */
`default_nettype none
module flash_program_write_control_assertions
  import flash_seq_pkg::*;
#(
  parameter int ERASE_COUNT   = 40,
  parameter int PROGRAM_COUNT = 20
)
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              ctrl_wr,
  input wire logic [7:0]        ctrl_wdata,
  input wire logic              nv_wr,
  input wire logic [7:0]        nv_wdata,
  input wire logic              instr_boundary,
  input wire logic              exec_internal,
  input wire logic              buf_wr,
  input wire logic [ADDR_W-1:0] buf_addr,
  input wire logic [7:0]        buf_wdata,
  input wire logic              brownout,
  input wire logic              irq_req,
  input wire logic [7:0]        array_rdata,
  input wire logic [7:0]        flash_control_reg,
  input wire logic [7:0]        nonvolatile_control_reg,
  input wire logic              cpu_stall,
  input wire logic              irq_take,
  input wire logic              array_we,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic [7:0]        array_wdata,
  input wire logic [1:0]        array_space
);
  wire logic busy = flash_control_reg[CTRL_BUSY_BIT];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence arm_seq;
    ctrl_wr && ctrl_wdata[7:4] == KEY_ARM && !busy;
  endsequence
  sequence launch_seq;
    arm_seq ##1 (ctrl_wr && ctrl_wdata[7:4] == KEY_LAUNCH && ctrl_wdata[2:1] != 2'h3);
  endsequence
  sequence reserved_seq;
    arm_seq ##1 (ctrl_wr && ctrl_wdata == 8'hA6);
  endsequence
  chk_launch_busy: assert property (launch_seq |-> ##[1:2] busy)
    else $error("launch did not raise busy");
  chk_reserved_idle: assert property (reserved_seq |=> !busy [*2])
    else $error("reserved space launched");
  chk_stall_internal: assert property ($rose(busy) && exec_internal |-> cpu_stall)
    else $error("internal write without stall");
  chk_run_external: assert property (busy && !exec_internal |-> !cpu_stall)
    else $error("external write stalled cpu");
  chk_stall_bounded: assert property (cpu_stall |-> busy)
    else $error("stall outside busy");
  chk_irq_held: assert property (cpu_stall && $past(cpu_stall) |-> !irq_take)
    else $error("irq taken while stalled");
  chk_irq_passes: assert property ((irq_req && !cpu_stall) [*2] |-> irq_take)
    else $error("irq lost while running");
  chk_busy_locked: assert property (busy && ctrl_wr ##1 busy |-> $stable(flash_control_reg[7:1]))
    else $error("control changed while busy");
  chk_write_busy: assert property (array_we |-> busy || $past(busy))
    else $error("array write while idle");
  chk_brownout_err: assert property (busy && brownout ##1 brownout [*4] |-> ##[0:3]
    nonvolatile_control_reg[NV_ERR_BIT])
    else $error("brownout left no error");
endmodule : flash_program_write_control_assertions
bind flash_program_write_control flash_program_write_control_assertions
  #(.ERASE_COUNT(ERASE_COUNT), .PROGRAM_COUNT(PROGRAM_COUNT)) chk_i (
  .clk(clk), .resetn(resetn), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .nv_wr(nv_wr),
  .nv_wdata(nv_wdata), .instr_boundary(instr_boundary), .exec_internal(exec_internal),
  .buf_wr(buf_wr), .buf_addr(buf_addr), .buf_wdata(buf_wdata), .brownout(brownout),
  .irq_req(irq_req), .array_rdata(array_rdata), .flash_control_reg(flash_control_reg),
  .nonvolatile_control_reg(nonvolatile_control_reg), .cpu_stall(cpu_stall), .irq_take(irq_take),
  .array_we(array_we), .array_addr(array_addr), .array_wdata(array_wdata), .array_space(array_space));
`default_nettype wire

/* dv/testbench.sv */
`default_nettype none
module testbench
  import flash_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, ctrl_wr, nv_wr, instr_boundary, exec_internal, buf_wr, brownout, irq_req;
  logic cpu_stall, irq_take, array_we, was_busy;
  logic [7:0] ctrl_wdata, nv_wdata, buf_wdata, array_rdata, flash_control_reg, nonvolatile_control_reg;
  logic [7:0] array_wdata;
  logic [1:0] array_space;
  logic [ADDR_W-1:0] buf_addr, array_addr;
  logic [7:0] shadow [256];
  typedef struct {int pg; bit chk; logic [7:0] err; logic [7:0] img [128];} note_type;
  note_type notes [$];
  note_type pn, gn;
  int n_errors, cmp_count;
  flash_program_write_control #(.ERASE_COUNT(2), .PROGRAM_COUNT(2)) flash_program_write_control_i (
    .clk(clk), .resetn(resetn), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .nv_wr(nv_wr),
    .nv_wdata(nv_wdata), .instr_boundary(instr_boundary), .exec_internal(exec_internal),
    .buf_wr(buf_wr), .buf_addr(buf_addr), .buf_wdata(buf_wdata), .brownout(brownout),
    .irq_req(irq_req), .array_rdata(array_rdata), .flash_control_reg(flash_control_reg),
    .nonvolatile_control_reg(nonvolatile_control_reg), .cpu_stall(cpu_stall), .irq_take(irq_take),
    .array_we(array_we), .array_addr(array_addr), .array_wdata(array_wdata), .array_space(array_space));
  flash_array_model flash_array_model_i (.clk(clk), .we(array_we), .addr(array_addr),
    .wdata(array_wdata), .rdata(array_rdata));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic ctrl(input logic [7:0] v);
    @(negedge clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = v;
  endtask : ctrl
  task automatic nv(input logic [7:0] v);
    @(negedge clk);
    nv_wr = 1'b1;
    nv_wdata = v;
    @(negedge clk);
    nv_wr = 1'b0;
  endtask : nv
  task automatic launch;
    ctrl(8'h50);
    ctrl(8'hA0);
    @(negedge clk);
    ctrl_wr = 1'b0;
  endtask : launch
  task automatic wait_idle;
    int t;
    for (t = 0; t < 3000 && flash_control_reg[CTRL_BUSY_BIT] !== 1'b0; t++) @(negedge clk);
    if (t == 3000)
    begin
      n_errors++;
      complete_run();
    end
  endtask : wait_idle
  // loads n bytes, notes the expected page, then launches
  task automatic prog(input int pg, input int h, input int n, input bit ers, input bit bo);
    int a;
    logic [7:0] d;
    if (ers)
      for (int j = 0; j < 128; j++) shadow[pg * 128 + j] = ERASED;
    ctrl(8'h08);
    for (int i = 0; i < n; i++)
    begin
      a = pg * 128 + h * 64 + (i * 7) % 64;
      d = 8'($urandom);
      @(negedge clk);
      ctrl_wr = 1'b0;
      buf_wr = 1'b1;
      buf_addr = 16'(a);
      buf_wdata = d;
      shadow[a] = shadow[a] & d;
    end
    @(negedge clk);
    ctrl_wr = 1'b0;
    buf_wr = 1'b0;
    pn.pg = pg;
    pn.chk = !bo;
    pn.err = {7'h00, bo};
    for (int j = 0; j < 128; j++) pn.img[j] = shadow[pg * 128 + j];
    notes.push_back(pn);
    launch();
  endtask : prog
  initial
  begin
    was_busy = 1'b0;
    forever
    begin
      @(negedge clk);
      if (was_busy === 1'b1 && flash_control_reg[CTRL_BUSY_BIT] === 1'b0 && notes.size() > 0)
      begin
        gn = notes.pop_front();
        check_val({7'h00, nonvolatile_control_reg[NV_ERR_BIT]}, gn.err, "err flag");
        for (int j = 0; j < 128; j++)
          if (gn.chk) check_val(flash_array_model_i.mem[gn.pg * 128 + j], gn.img[j], "page");
      end
      was_busy = flash_control_reg[CTRL_BUSY_BIT];
    end
  end
  initial
  begin
    {ctrl_wr, nv_wr, instr_boundary, buf_wr, brownout, resetn} = '0;
    {irq_req, exec_internal} = 2'b11;
    {ctrl_wdata, nv_wdata, buf_wdata, buf_addr} = '0;
    n_errors = 0;
    cmp_count = 0;
    for (int i = 0; i < 256; i++) shadow[i] = 8'(i * 37 + 5);
    void'($urandom(77));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    check_val(flash_control_reg, 8'h00, "ctrl reset");
    check_val({7'h00, cpu_stall}, 8'h00, "stall reset");
    // second pass rewrites the same bytes, only clearing more bits
    for (int p = 0; p < 2; p++)
    begin
      exec_internal = (p == 0);
      irq_req = (p == 0);
      prog(1, 0, 8, 1'b0, 1'b0);
      @(negedge clk);
      check_val({7'h00, cpu_stall}, {7'h00, exec_internal}, "stall");
      check_val(flash_control_reg & 8'h01, 8'h01, "busy");
      check_val({7'h00, irq_take}, 8'h00, "irq held");
      if (p == 1) launch();
      wait_idle();
      repeat (4) @(negedge clk);
      check_val(flash_control_reg & 8'h01, 8'h00, "relaunch");
      check_val({7'h00, irq_take}, {7'h00, irq_req}, "irq after");
    end
    nv(8'h40);
    check_val(nonvolatile_control_reg, 8'h40, "auto_erase_bit");
    prog(1, 1, 5, 1'b1, 1'b0);
    wait_idle();
    prog(1, 1, 0, 1'b1, 1'b0);
    wait_idle();
    nv(8'h00);
    for (int c = 0; c < 2; c++)
    begin
      ctrl(c ? 8'h56 : 8'h50);
      if (c == 0)
      begin
        @(negedge clk);
        ctrl_wr = 1'b0;
        instr_boundary = 1'b1;
      end
      ctrl(c ? 8'hA6 : 8'hA0);
      instr_boundary = 1'b0;
      @(negedge clk);
      ctrl_wr = 1'b0;
      repeat (2) @(negedge clk);
      check_val(flash_control_reg & 8'h01, 8'h00, "refused");
      check_val({6'h00, array_space}, c ? {6'h00, SPACE_RSVD} : 8'h00, "space");
    end
    prog(0, 0, 4, 1'b0, 1'b1);
    repeat (6) @(negedge clk);
    brownout = 1'b1;
    wait_idle();
    brownout = 1'b0;
    repeat (4) @(negedge clk);
    nv(8'h00);
    check_val(nonvolatile_control_reg, 8'h00, "err clear");
    check_val(8'(notes.size()), 8'h00, "notes left");
    complete_run();
  end
endmodule : testbench
`default_nettype wire

/* hw/cycle_timer.sv */
`default_nettype none
module cycle_timer
  import flash_seq_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          start,
  input  wire logic [W-1:0]  count,
  output logic               done
);
  logic [W-1:0] remain;
  logic [W-1:0] next_remain;
  logic         next_done;
  always_comb
  begin
    next_remain = remain;
    next_done   = 1'b0;
    if (start)
      next_remain = count;
    else if (remain != '0)
    begin
      next_remain = remain - W'(1);
      next_done   = (remain == W'(1));
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      remain <= '0;
      done   <= 1'b0;
    end
    else
    begin
      remain <= next_remain;
      done   <= next_done;
    end
  end
endmodule : cycle_timer
`default_nettype wire

/* hw/flash_program_write_control.sv */
// Notes on behaviour
// RULE1: internal launch stalls CPU whole write
// RULE2: CPU resumes at next instruction after
// RULE3: peripherals keep running during stall
// RULE4: interrupts held pending until write ends
// RULE5: external launch lets CPU keep running
// RULE6: external software polls busy flag
// RULE7: external software keeps interrupts disabled
// RULE8: external software avoids internal flash jumps
// RULE9: boot ROM writes run without stall
// RULE10: write only clears bits to zero
// RULE11: erase sets whole page to ones
// RULE12: zero-clearing rewrite needs no erase
// RULE13: raising bits needs save, erase, rewrite
// RULE14: 128-byte pages, one page per write
// RULE15: launch needs key 5 then A
// RULE16: busy during write; brown-out sets error
// RULE17: 64-byte stage buffer cleared after use
// RULE18: auto-erase erases page, unloaded stay ones
// RULE19: launch ignored while busy
// RULE20: busy readable in both modes
`default_nettype none
module flash_program_write_control
  import flash_seq_pkg::*;
#(
  parameter int ERASE_COUNT   = ERASE_CYCLES,
  parameter int PROGRAM_COUNT = PROGRAM_CYCLES
)
(
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic                         ctrl_wr,
  input  wire logic [7:0]                   ctrl_wdata,
  input  wire logic                         nv_wr,
  input  wire logic [7:0]                   nv_wdata,
  input  wire logic                         instr_boundary,
  input  wire logic                         exec_internal,
  input  wire logic                         buf_wr,
  input  wire logic [flash_seq_pkg::ADDR_W-1:0] buf_addr,
  input  wire logic [7:0]                   buf_wdata,
  input  wire logic                         brownout,
  input  wire logic                         irq_req,
  input  wire logic [7:0]                   array_rdata,
  output logic [7:0]                        flash_control_reg,
  output logic [7:0]                        nonvolatile_control_reg,
  output logic                              cpu_stall,
  output logic                              irq_take,
  output logic                              array_we,
  output logic [flash_seq_pkg::ADDR_W-1:0]  array_addr,
  output logic [7:0]                        array_wdata,
  output logic [1:0]                        array_space
);
  localparam int TW = 16;
  seq_state_type state;
  seq_state_type next_state;
  logic [3:0]        launch_key_field;
  logic              fps;
  logic [1:0]        fmod;
  logic              flash_busy_flag;
  logic              auto_erase_bit;
  logic              err;
  logic              stalled;
  logic [PAGE_W-1:0] page;
  logic [6:0]        idx;
  logic              half;
  logic [2:0]        bo_sync;
  logic              bo_level;
  logic [3:0]        next_key;
  logic              next_fps;
  logic [1:0]        next_fmod;
  logic              next_busy;
  logic              next_auto_erase_bit;
  logic              next_err;
  logic              next_stalled;
  logic [PAGE_W-1:0] next_page;
  logic [6:0]        next_idx;
  logic              next_half;
  logic              next_bo_level;
  logic              next_we;
  logic [ADDR_W-1:0] next_addr;
  logic [7:0]        next_wdata;
  logic              t_start;
  logic [TW-1:0]     t_count;
  logic              t_done;
  logic              buf_clear;
  logic [7:0]        rd_data;
  logic              rd_loaded;
  logic              any_loaded;
  logic              launch;
  logic              key_ok;
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [PAGE_W-1:0] p, input logic [6:0] o);
    byte_addr = {p, o};
  endfunction : byte_addr
  page_stage_buffer #(.DEPTH(HALF_BYTES)) u_buf
  (
    .clk        (clk),
    .resetn     (resetn),
    .load       (buf_wr && fps),
    .load_ofs   (buf_addr[OFS_W-1:0]),
    .load_data  (buf_wdata),
    .clear      (buf_clear),
    .rd_ofs     (idx[OFS_W-1:0]),
    .rd_data    (rd_data),
    .rd_loaded  (rd_loaded),
    .any_loaded (any_loaded)
  );
  cycle_timer #(.W(TW)) u_timer
  (
    .clk    (clk),
    .resetn (resetn),
    .start  (t_start),
    .count  (t_count),
    .done   (t_done)
  );
  // brown-out is asynchronous: three stages, accepted when last two agree
  always_comb
  begin
    next_bo_level = bo_level;
    if (bo_sync[1] == bo_sync[2])
      next_bo_level = bo_sync[2];
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bo_sync  <= '0;
      bo_level <= 1'b0;
    end
    else
    begin
      bo_sync  <= {bo_sync[1:0], brownout};
      bo_level <= next_bo_level;
    end
  end
  // a reserved space launches nothing
  assign key_ok = ctrl_wr && (ctrl_wdata[7:CTRL_KEY_LSB] == KEY_LAUNCH)
                  && (ctrl_wdata[CTRL_MOD_LSB +: 2] != SPACE_RSVD);
  always_comb
  begin
    next_state   = state;
    next_key     = launch_key_field;
    next_fps     = fps;
    next_fmod    = fmod;
    next_busy    = flash_busy_flag;
    next_auto_erase_bit    = auto_erase_bit;
    next_err     = err;
    next_stalled = stalled;
    next_page    = page;
    next_idx     = idx;
    next_half    = half;
    next_we      = 1'b0;
    next_addr    = array_addr;
    next_wdata   = array_wdata;
    t_start      = 1'b0;
    t_count      = '0;
    buf_clear    = 1'b0;
    launch       = 1'b0;
    if (nv_wr)
      next_auto_erase_bit = nv_wdata[NV_AUTO_ERASE_BIT_BIT];
    // last loaded address picks the page and half
    if (buf_wr && fps)
    begin
      next_page = buf_addr[ADDR_W-1:7];
      next_half = buf_addr[OFS_W];
    end
    if (ctrl_wr && !flash_busy_flag)
    begin
      next_key  = ctrl_wdata[7:CTRL_KEY_LSB];
      next_fps  = ctrl_wdata[CTRL_FPS_BIT];
      next_fmod = ctrl_wdata[CTRL_MOD_LSB +: 2];
    end
    unique case (state)
      ST_IDLE:
      begin
        if (ctrl_wr && ctrl_wdata[7:CTRL_KEY_LSB] == KEY_ARM)
          next_state = ST_ARMED; // RULE15
      end
      ST_ARMED:
      begin
        // any other instruction between the keys aborts
        if (key_ok)
          launch = 1'b1; // RULE15
        else if (instr_boundary || ctrl_wr)
          next_state = ST_IDLE;
      end
      ST_ERASE:
      begin
        // blank writes wait for the erase time, then run one per cycle
        if (t_done || idx != 7'd0)
        begin
          next_we    = 1'b1;
          next_addr  = byte_addr(page, idx);
          next_wdata = ERASED; // RULE11
          next_idx   = idx + 7'd1;
          if (idx == 7'(PAGE_BYTES - 1))
          begin
            next_state = ST_PROGRAM;
            next_idx   = {half, 6'd0};
            t_start    = 1'b1;
            t_count    = TW'(PROGRAM_COUNT);
          end
        end
      end
      ST_PROGRAM:
      begin
        // address leads the write so array_rdata is the target byte
        next_addr = byte_addr(page, idx);
        if (t_done)
        begin
          // unloaded bytes are masked with FF, so stay as they were or blank
          next_we    = 1'b1; // RULE18
          next_wdata = array_rdata & (rd_loaded ? rd_data : ERASED); // RULE10 RULE12
          next_idx   = idx + 7'd1;
          if (idx[OFS_W-1:0] == OFS_W'(HALF_BYTES - 1))
            next_state = ST_FINISH; // RULE14
          else
          begin
            t_start = 1'b1;
            t_count = TW'(1);
          end
        end
      end
      ST_FINISH:
      begin
        next_state   = ST_IDLE;
        next_busy    = 1'b0; // RULE16 RULE20
        next_stalled = 1'b0; // RULE2
        buf_clear    = 1'b1; // RULE17
        next_key     = '0;
      end
      default:
        next_state = ST_IDLE;
    endcase
    if (launch)
    begin
      next_busy    = 1'b1; // RULE16 RULE19
      next_stalled = exec_internal; // RULE1 RULE5 RULE9
      next_key     = KEY_LAUNCH;
      next_idx     = auto_erase_bit ? 7'd0 : {half, 6'd0};
      next_state   = auto_erase_bit ? ST_ERASE : ST_PROGRAM; // RULE18
      t_start      = 1'b1;
      t_count      = auto_erase_bit ? TW'(ERASE_COUNT) : TW'(PROGRAM_COUNT);
    end
    // brown-out aborts the operation and flags it
    if (bo_level && flash_busy_flag)
    begin
      next_err     = 1'b1; // RULE16
      next_state   = ST_IDLE;
      next_busy    = 1'b0;
      next_stalled = 1'b0;
      next_we      = 1'b0;
      buf_clear    = 1'b1;
    end
    else if (nv_wr && !nv_wdata[NV_ERR_BIT])
      next_err = 1'b0;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state            <= ST_IDLE;
      launch_key_field <= '0;
      fps              <= 1'b0;
      fmod             <= SPACE_USER;
      flash_busy_flag  <= 1'b0;
      auto_erase_bit   <= 1'b0;
      err              <= 1'b0;
      stalled          <= 1'b0;
      page             <= '0;
      idx              <= '0;
      half             <= 1'b0;
      array_we         <= 1'b0;
      array_addr       <= '0;
      array_wdata      <= '0;
    end
    else
    begin
      state            <= next_state;
      launch_key_field <= next_key;
      fps              <= next_fps;
      fmod             <= next_fmod;
      flash_busy_flag  <= next_busy;
      auto_erase_bit   <= next_auto_erase_bit;
      err              <= next_err;
      stalled          <= next_stalled;
      page             <= next_page;
      idx              <= next_idx;
      half             <= next_half;
      array_we         <= next_we;
      array_addr       <= next_addr;
      array_wdata      <= next_wdata;
    end
  end
  // only the CPU core stalls; peripherals keep their own clock
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flash_control_reg       <= '0;
      nonvolatile_control_reg <= '0;
      cpu_stall               <= 1'b0;
      irq_take                <= 1'b0;
      array_space             <= SPACE_USER;
    end
    else
    begin
      flash_control_reg       <= {next_key, next_fps, next_fmod, next_busy}; // RULE20
      nonvolatile_control_reg <= {1'b0, next_auto_erase_bit, 4'h0, next_err, 1'b0};
      cpu_stall               <= next_stalled; // RULE1 RULE3
      irq_take                <= irq_req && !next_stalled; // RULE4
      array_space             <= next_fmod;
    end
  end
endmodule : flash_program_write_control
`default_nettype wire

/* hw/flash_seq_pkg.sv */
`default_nettype none
package flash_seq_pkg;
  localparam int ADDR_W       = 16;
  localparam int PAGE_BYTES   = 128;
  localparam int HALF_BYTES   = 64;
  localparam int OFS_W        = 6;
  localparam int PAGE_W       = 9;
  localparam logic [3:0] KEY_ARM    = 4'h5;
  localparam logic [3:0] KEY_LAUNCH = 4'hA;
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam logic [1:0] SPACE_USER = 2'h0;
  localparam logic [1:0] SPACE_SIG  = 2'h1;
  localparam logic [1:0] SPACE_FUSE = 2'h2;
  localparam logic [1:0] SPACE_RSVD = 2'h3;
  localparam int CTRL_KEY_LSB  = 4;
  localparam int CTRL_FPS_BIT  = 3;
  localparam int CTRL_MOD_LSB  = 1;
  localparam int CTRL_BUSY_BIT = 0;
  localparam int NV_AUTO_ERASE_BIT_BIT   = 6;
  localparam int NV_ERR_BIT    = 1;
  localparam int ERASE_TIME_US   = 4;
  localparam int PROGRAM_TIME_US = 2;
  localparam int CLK_MHZ         = 10;
  localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,
    ST_ARMED   = 3'b001,
    ST_ERASE   = 3'b010,
    ST_PROGRAM = 3'b011,
    ST_FINISH  = 3'b100
  } seq_state_type;
endpackage : flash_seq_pkg
`default_nettype wire

/* hw/page_stage_buffer.sv */
`default_nettype none
module page_stage_buffer
  import flash_seq_pkg::*;
#(
  parameter int DEPTH = HALF_BYTES
)
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 load,
  input  wire logic [OFS_W-1:0]     load_ofs,
  input  wire logic [7:0]           load_data,
  input  wire logic                 clear,
  input  wire logic [OFS_W-1:0]     rd_ofs,
  output logic      [7:0]           rd_data,
  output logic                      rd_loaded,
  output logic                      any_loaded
);
  logic [7:0]       mem [DEPTH];
  logic [DEPTH-1:0] loaded;
  logic [DEPTH-1:0] next_loaded;
  // once loaded a location cannot be reloaded
  always_comb
  begin
    next_loaded = loaded;
    if (clear)
      next_loaded = '0; // RULE17
    else if (load)
      next_loaded[load_ofs] = 1'b1;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      loaded <= '0;
    else
      loaded <= next_loaded;
  end
  // data array has no reset; loaded bits qualify it
  always_ff @(posedge clk)
  begin
    if (load && !clear && !loaded[load_ofs])
      mem[load_ofs] <= load_data;
  end
  assign rd_data    = mem[rd_ofs];
  assign rd_loaded  = loaded[rd_ofs];
  assign any_loaded = |loaded;
endmodule : page_stage_buffer
`default_nettype wire
